// >>> hw/dmb_pkg.sv
// Package for the DDR2 multi-bank command tracker: encodings, timings.
// Assumes commands arrive sampled on the memory clock's rising edge.
package dmb_pkg;
    // ----------------------------------------------------------------
    // Command encodings {cs_n, ras_n, cas_n, we_n}
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_LM  = 4'h0;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int AP_BIT    = 10;
    localparam int BL_FIELD  = 0;
    localparam logic [2:0] BL4_CODE = 3'h2;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [3:0] BL_RESET = 4'h4;
    // ----------------------------------------------------------------
    // Timings in memory clocks
    // ----------------------------------------------------------------
    localparam int T_RCD = 4;
    localparam int T_RP  = 4;
    localparam int T_WR  = 4;
    localparam int T_MRD = 2;
    localparam int CL    = 4;
    localparam int WL    = CL - 1;
    typedef enum logic [2:0] {
        DMB_IDLE = 3'h0,
        DMB_ACTV = 3'h1,
        DMB_OPEN = 3'h3,
        DMB_BRST = 3'h2,
        DMB_PREC = 3'h6
    } dmb_bank_t;
endpackage

// >>> hw/dmb_edge.sv
// Two-flop synchroniser with rising-edge detect for the memory clock.
// Assumes the sampled clock is well below half the system clock.
`timescale 1ns/1ps
module dmb_edge (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_sig,
    output logic      o_rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } dmb_edge_t;
    dmb_edge_t st_reg, st_next;
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = i_sig;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_rise = st_reg.s2 & ~st_reg.s3;
endmodule // dmb_edge

// >>> hw/dmb_banks.sv
// Notes on behaviour
// - Decode NOP, ACT, RD, WR, PRE encodings
// - Deselect executes nothing, work continues
// - NOP registers nothing, work continues
// - Read auto-precharge starts after burst
// - Write auto-precharge starts after tWR
// - Access period ends as tRP starts
// - Accept other-bank commands during auto-precharge
// - Bank address picks mode register
// - Idle means precharged, tRP met
// - Active means opened, tRCD met
// - A10 selects auto precharge
// - Burst length four or eight
//
// Device-side bank state tracker. Link pins come from another clock
// domain; the memory clock is sampled and its rising edges found here.
`timescale 1ns/1ps
module dmb_banks #(
    parameter int NB = 8,
    parameter int AW = 14
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_rst_n,
    input  wire logic          i_mem_clk,
    input  wire logic          i_cke,
    input  wire logic          i_cs_n,
    input  wire logic          i_ras_n,
    input  wire logic          i_cas_n,
    input  wire logic          i_we_n,
    input  wire logic [2:0]    i_ba,
    input  wire logic [AW-1:0] i_addr,
    output logic [NB-1:0]      o_bank_idle,
    output logic [NB-1:0]      o_bank_open,
    output logic [NB-1:0]      o_bank_prech,
    output logic [3:0]         o_burst_len,
    output logic [AW-1:0]      o_mode_val,
    output logic [1:0]         o_mode_sel,
    output logic               o_mode_busy
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int PW = 5 + 3 + AW;
    logic [PW-1:0] pin_s1, pin_s2;
    logic          mclk_rise;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= {PW{1'b1}};
            pin_s2 <= {PW{1'b1}};
        end else begin
            pin_s1 <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba,
                       i_addr};
            pin_s2 <= pin_s1;
        end
    end
    dmb_edge u_edge (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_sig     (i_mem_clk),
        .o_rise    (mclk_rise)
    );
    logic          cke_now;
    logic [3:0]    cmd;
    logic [2:0]    ba;
    logic [AW-1:0] addr;
    assign cke_now = pin_s2[PW-1];
    assign cmd     = pin_s2[PW-2 -: 4];
    assign ba      = pin_s2[AW+2 -: 3];
    assign addr    = pin_s2[AW-1:0];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NB-1:0][2:0] bst;
        logic [NB-1:0][4:0] cnt;
        logic [NB-1:0]      ap;
        logic [NB-1:0]      wr;
        logic               cke_prev;
        logic [3:0]         bl;
        logic [AW-1:0]      mval;
        logic [1:0]         msel;
        logic [2:0]         mcnt;
    } dmb_state_t;
    dmb_state_t st_reg, st_next;

    logic valid_edge;
    logic all_idle;
    // Clock enable must be high on previous and current edge
    assign valid_edge = mclk_rise & cke_now & st_reg.cke_prev;

    always_comb begin
        st_next  = st_reg;
        all_idle = 1'b1;
        for (int b = 0; b < NB; b++) begin
            all_idle &= (st_reg.bst[b] == dmb_pkg::DMB_IDLE);
        end
        if (mclk_rise) begin
            st_next.cke_prev = cke_now;
            if (st_reg.mcnt != 3'h0) begin
                st_next.mcnt = st_reg.mcnt - 3'h1;
            end
            for (int b = 0; b < NB; b++) begin
                if (st_reg.cnt[b] != 5'h0) begin
                    st_next.cnt[b] = st_reg.cnt[b] - 5'h1;
                end else begin
                    case (st_reg.bst[b])
                        dmb_pkg::DMB_ACTV: begin
                            st_next.bst[b] = dmb_pkg::DMB_OPEN;
                        end
                        dmb_pkg::DMB_BRST: begin
                            if (st_reg.ap[b]) begin
                                // Access period ends, tRP begins
                                st_next.bst[b] = dmb_pkg::DMB_PREC;
                                st_next.cnt[b] = 5'(dmb_pkg::T_RP - 1);
                            end else begin
                                st_next.bst[b] = dmb_pkg::DMB_OPEN;
                            end
                        end
                        dmb_pkg::DMB_PREC: begin
                            st_next.bst[b] = dmb_pkg::DMB_IDLE;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        // Deselect and NOP fall through: counters still run
        if (valid_edge && cmd[3] == 1'b0 &&
            cmd != dmb_pkg::CMD_NOP) begin
            case (cmd)
                dmb_pkg::CMD_ACT: begin
                    st_next.bst[ba] = dmb_pkg::DMB_ACTV;
                    st_next.cnt[ba] = 5'(dmb_pkg::T_RCD - 1);
                end
                dmb_pkg::CMD_RD, dmb_pkg::CMD_WR: begin
                    // Other banks keep running: concurrent auto precharge
                    st_next.bst[ba] = dmb_pkg::DMB_BRST;
                    st_next.ap[ba]  = addr[dmb_pkg::AP_BIT];
                    st_next.wr[ba]  = (cmd == dmb_pkg::CMD_WR);
                    if (cmd == dmb_pkg::CMD_RD) begin
                        // Earliest explicit precharge: BL/2 after read
                        st_next.cnt[ba] = 5'(st_reg.bl / 2 - 1);
                    end else begin
                        // Latency and burst; tWR only before auto precharge
                        st_next.cnt[ba] = 5'(dmb_pkg::WL + st_reg.bl / 2 - 1
                        + (addr[dmb_pkg::AP_BIT] ? dmb_pkg::T_WR : 0));
                    end
                end
                dmb_pkg::CMD_PRE: begin
                    if (addr[dmb_pkg::AP_BIT]) begin
                        for (int b = 0; b < NB; b++) begin
                            st_next.bst[b] = dmb_pkg::DMB_PREC;
                            st_next.cnt[b] = 5'(dmb_pkg::T_RP - 1);
                        end
                    end else begin
                        st_next.bst[ba] = dmb_pkg::DMB_PREC;
                        st_next.cnt[ba] = 5'(dmb_pkg::T_RP - 1);
                    end
                end
                dmb_pkg::CMD_LM: begin
                    // Ignored unless every bank idle
                    if (all_idle) begin
                        st_next.msel = ba[1:0];
                        st_next.mval = addr;
                        st_next.mcnt = 3'(dmb_pkg::T_MRD);
                        if (ba[1:0] == 2'h0) begin
                            if (addr[2:0] == dmb_pkg::BL8_CODE) begin
                                st_next.bl = 4'h8;
                            end else if (addr[2:0] == dmb_pkg::BL4_CODE) begin
                                st_next.bl = 4'h4;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg    <= '0;
            st_reg.bl <= dmb_pkg::BL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            o_bank_idle[b]  = st_reg.bst[b] == dmb_pkg::DMB_IDLE;
            o_bank_open[b]  = st_reg.bst[b] == dmb_pkg::DMB_OPEN;
            o_bank_prech[b] = st_reg.bst[b] == dmb_pkg::DMB_PREC;
        end
    end
    assign o_burst_len = st_reg.bl;
    assign o_mode_val  = st_reg.mval;
    assign o_mode_sel  = st_reg.msel;
    assign o_mode_busy = st_reg.mcnt != 3'h0;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    rd_ap_prec_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        st_reg.bst[0] == dmb_pkg::DMB_BRST &&
        st_next.bst[0] == dmb_pkg::DMB_PREC &&
        !(valid_edge && cmd == dmb_pkg::CMD_PRE) |->
        st_reg.ap[0] && st_reg.cnt[0] == 5'h0)
        else $error("Precharge started without auto precharge");
    act_open_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_bank_open[0]) |->
        $past(st_reg.bst[0]) != dmb_pkg::DMB_IDLE)
        else $error("Bank opened straight from idle");
    idle_prec_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_bank_idle[0]) |-> $past(o_bank_prech[0]))
        else $error("Bank idle without precharge");
    nop_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mclk_rise && (cmd[3] || cmd == dmb_pkg::CMD_NOP) &&
        st_reg.cnt[0] != 5'h0 |=> $stable(st_reg.bst[0]))
        else $error("State moved on a deselect or no-op");
    lm_idle_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_mode_busy) |-> $past(all_idle))
        else $error("Mode load accepted with banks busy");
    bl_legal_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_burst_len == 4'h4 || o_burst_len == 4'h8)
        else $error("Burst length not four or eight");
    ap_cap_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        valid_edge && cmd == dmb_pkg::CMD_RD && ba == 3'h0 |=>
        st_reg.ap[0] == $past(addr[dmb_pkg::AP_BIT]))
        else $error("Auto precharge flag not captured");
    cke_gate_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mclk_rise && !valid_edge && cmd == dmb_pkg::CMD_ACT &&
        st_reg.bst[ba] == dmb_pkg::DMB_IDLE |->
        st_next.bst[ba] == dmb_pkg::DMB_IDLE)
        else $error("Command taken with clock enable low");
    c_act: cover property (@(posedge i_clk_sys) o_bank_open[0]);
    c_prec: cover property (@(posedge i_clk_sys) o_bank_prech[1]);
    c_lm: cover property (@(posedge i_clk_sys) o_mode_busy);
endmodule // dmb_banks

// >>> verification/dmb_ctrl_model.sv
// Controller-side model: free memory clock and DDR2 command pins.
// Assumes the bench calls put() once for every memory clock.
`timescale 1ns/1ps
module dmb_ctrl_model #(
    parameter int TWTR = 2
) (
    input  wire logic   i_clk_sys,
    output logic        o_mem_clk,
    output logic        o_cke,
    output logic [3:0]  o_cmd,
    output logic [2:0]  o_ba,
    output logic [13:0] o_addr
);
    int ph = 0;
    int rd_w = 0;
    int wr_w = 0;
    int mrd_w = 0;
    initial begin
        o_mem_clk = 1'b0;
        o_cke = 1'b1;
        o_cmd = dmb_pkg::CMD_NOP;
        o_ba = 3'h0;
        o_addr = 14'h0;
    end
    // ----------------------------------------------------------------
    // Clock and spacing counters
    // ----------------------------------------------------------------
    always @(negedge i_clk_sys) begin
        ph = (ph + 1) % 4;
        if (ph == 0)
            o_mem_clk = ~o_mem_clk;
    end
    always @(posedge o_mem_clk) begin
        rd_w = (rd_w > 0) ? rd_w - 1 : 0;
        wr_w = (wr_w > 0) ? wr_w - 1 : 0;
        mrd_w = (mrd_w > 0) ? mrd_w - 1 : 0;
    end
    // Pins hold until the next put, as a real controller keeps driving
    task automatic put(input logic k, input logic [3:0] c,
                       input logic [2:0] b, input logic [13:0] a,
                       input int bl);
        @(negedge o_mem_clk);
        while ((c != dmb_pkg::CMD_NOP && mrd_w > 0) ||
               (c == dmb_pkg::CMD_RD && rd_w > 0) ||
               (c == dmb_pkg::CMD_WR && wr_w > 0)) begin
            o_cmd = dmb_pkg::CMD_NOP;
            @(negedge o_mem_clk);
        end
        o_cke = k;
        o_cmd = c;
        o_ba = b;
        o_addr = a;
        if (c == dmb_pkg::CMD_RD) begin
            rd_w = bl / 2;
            wr_w = bl / 2 + 2;
        end
        if (c == dmb_pkg::CMD_WR) begin
            rd_w = dmb_pkg::CL - 1 + bl / 2 + TWTR;
            wr_w = bl / 2;
        end
        if (c == dmb_pkg::CMD_LM)
            mrd_w = dmb_pkg::T_MRD;
    endtask
endmodule // dmb_ctrl_model

// >>> verification/dmb_banks_tb_top.sv
// Bench for the bank tracker: a bank model is compared each memory clock.
// Assumes the controller model drives the memory clock and command pins.
`timescale 1ns/1ps
module dmb_banks_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        mclk, cke, mbusy;
    logic [3:0]  cmd, blen;
    logic [2:0]  ba;
    logic [13:0] addr, mval, a;
    logic [7:0]  idle_v, open_v, prch_v;
    logic [1:0]  msel;
    int          n_errors = 0;
    int          checks_done = 0;
    int          st[8], cnt[8];
    bit          ap[8];
    int          bl = 4, mb = 0, mv = 0, ms = 0, b, c;
    bit          cke_q = 1'b1, run = 1'b0;
    always #5 clk = ~clk;
    dmb_ctrl_model i_dmb_ctrl_model (.i_clk_sys(clk), .o_mem_clk(mclk),
        .o_cke(cke), .o_cmd(cmd), .o_ba(ba), .o_addr(addr));
    dmb_banks #(.NB(8), .AW(14)) i_dmb_banks (.i_clk_sys(clk),
        .i_rst_n(rst_n), .i_mem_clk(mclk), .i_cke(cke), .i_cs_n(cmd[3]),
        .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
        .i_addr(addr), .o_bank_idle(idle_v), .o_bank_open(open_v),
        .o_bank_prech(prch_v), .o_burst_len(blen), .o_mode_val(mval),
        .o_mode_sel(msel), .o_mode_busy(mbusy));
    function automatic bit all_idle();
        foreach (st[i]) if (st[i] != 0) return 1'b0;
        return 1'b1;
    endfunction
    function automatic logic [7:0] vec(int s);
        vec = 8'h0;
        foreach (st[i]) vec[i] = (st[i] == s);
    endfunction
    task automatic cmp_bank(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_mode(string nm, logic [13:0] e, logic [13:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic send(logic k, logic [3:0] cc, logic [2:0] bb,
                        logic [13:0] aa);
        i_dmb_ctrl_model.put(k, cc, bb, aa, bl);
        // Next choice must see the bank model after this edge
        @(posedge mclk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Bank model, stepped on each rising memory clock edge
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (run) begin
            mb = (mb > 0) ? mb - 1 : 0;
            foreach (st[i]) begin
                if (cnt[i] > 0) begin
                    cnt[i]--;
                    if (cnt[i] == 0 && st[i] == 3 && ap[i]) begin
                        st[i] = 4;
                        cnt[i] = dmb_pkg::T_RP;
                    end else if (cnt[i] == 0)
                        st[i] = (st[i] == 4) ? 0 : 2;
                end
            end
            if (cke && cke_q && !cmd[3]) begin
                case (cmd)
                dmb_pkg::CMD_ACT: begin
                    st[ba] = 1;
                    cnt[ba] = dmb_pkg::T_RCD;
                end
                dmb_pkg::CMD_RD, dmb_pkg::CMD_WR: begin
                    st[ba] = 3;
                    ap[ba] = addr[dmb_pkg::AP_BIT];
                    cnt[ba] = bl / 2 + ((cmd == dmb_pkg::CMD_RD) ? 0 :
                        dmb_pkg::WL + (ap[ba] ? dmb_pkg::T_WR : 0));
                end
                dmb_pkg::CMD_PRE: begin
                    foreach (st[i]) begin
                        if (i == ba || addr[dmb_pkg::AP_BIT]) begin
                            st[i] = 4;
                            cnt[i] = dmb_pkg::T_RP;
                        end
                    end
                end
                dmb_pkg::CMD_LM: if (all_idle()) begin
                    mv = addr;
                    ms = ba[1:0];
                    mb = dmb_pkg::T_MRD;
                    if (ba == 3'h0)
                        bl = (addr[2:0] == dmb_pkg::BL8_CODE) ? 8 : 4;
                end
                default: ;
                endcase
            end
        end
        cke_q = cke;
    end
    // Sampled late in the memory cycle, after the synchroniser delay
    always @(posedge mclk) begin
        if (run) begin
            #70;
            cmp_bank("idle", vec(0), idle_v);
            cmp_bank("open", vec(2), open_v);
            cmp_bank("prech", vec(4), prch_v);
            cmp_mode("burst_len", 14'(bl), {10'h0, blen});
            cmp_mode("mode_val", 14'(mv), mval);
            cmp_mode("mode_sel", 14'(ms), {12'h0, msel});
            cmp_mode("mode_busy", 14'(mb > 0), {13'h0, mbusy});
        end
    end
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h0de6));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        run = 1'b1;
        send(1'b0, dmb_pkg::CMD_ACT, 3'h1, 14'h0);
        send(1'b1, dmb_pkg::CMD_ACT, 3'h2, 14'h0);
        send(1'b1, 4'hb, 3'h3, 14'h0);
        send(1'b1, dmb_pkg::CMD_NOP, 3'h4, 14'h0);
        send(1'b1, dmb_pkg::CMD_LM, 3'h0, 14'h3);
        send(1'b1, dmb_pkg::CMD_LM, 3'h1, 14'($urandom));
        send(1'b1, dmb_pkg::CMD_ACT, 3'h3, 14'h0);
        send(1'b1, dmb_pkg::CMD_LM, 3'h0, 14'h2);
        repeat (400) begin
            b = $urandom % 8;
            c = $urandom % 5;
            a = 14'($urandom);
            if (c == 0 && st[b] == 0)
                send(1'b1, dmb_pkg::CMD_ACT, 3'(b), a);
            else if (c < 3 && st[b] == 2)
                send(1'b1, (c == 1) ? dmb_pkg::CMD_RD : dmb_pkg::CMD_WR,
                     3'(b), a);
            else if (c == 3 && st[b] == 2)
                send(1'b1, dmb_pkg::CMD_PRE, 3'(b), a & 14'h3bff);
            else if (c == 4 && all_idle())
                send(1'b1, dmb_pkg::CMD_LM, 3'(b % 4), {a[13:3], 2'h1, a[0]});
            else
                send(1'b1, {c[0], 3'h7}, 3'(b), a);
        end
        repeat (20) send(1'b1, dmb_pkg::CMD_NOP, 3'h0, 14'h0);
        // All bursts settled: close every bank at once
        send(1'b1, dmb_pkg::CMD_PRE, 3'h0, 14'h0400);
        repeat (8) send(1'b1, dmb_pkg::CMD_NOP, 3'h0, 14'h0);
        tally_and_finish();
    end
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
endmodule // dmb_banks_tb_top
